// >>> logic/acc_defines.svh
// register offsets, field positions and reset values for the converter control
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFF_SC1 8'h00
`define ACC_OFF_SC2 8'h04
`define ACC_OFF_RESH 8'h08
`define ACC_OFF_RESL 8'h0C
`define ACC_OFF_CVH 8'h10
`define ACC_OFF_CVL 8'h14
`define ACC_OFF_IST 8'h18
`define ACC_OFF_IMSK 8'h1C
`define ACC_SC1_FLAG 7
`define ACC_SC1_IEN 6
`define ACC_SC1_CONT 5
`define ACC_SC2_ACT 7
`define ACC_SC2_HWT 0
`define ACC_SC2_CMPE 1
`define ACC_SC2_CMPGT 2
`define ACC_SC2_M10 3
`define ACC_CH_OFF 5'h1F
`define ACC_RST_CH 5'h1F
`define ACC_RST_BYTE 8'h00
`define ACC_CVH_MASK 8'h03
`define ACC_IST_DONE 0
`define ACC_IST_MATCH 1
`define ACC_CONV_CYCLES 24
`endif

// >>> logic/acc_pkg.sv
// types shared by the converter control block
package acc_pkg;
   typedef enum logic {
      ACC_IDLE,
      ACC_CONV
   } acc_state_t;
   typedef struct packed {
      logic powerOn;
      logic isolate;
      logic [4:0] channel;
   } acc_front_t;
   typedef struct packed {
      logic hwTrig;
      logic cmpEn;
      logic cmpGt;
      logic mode10;
   } acc_cfg_t;
endpackage : acc_pkg

// >>> logic/acc_conversion_control.sv
// converter control: apb registers, trigger, sequencing, compare and interrupt
// Summary of operation
// - flag sets on every end without compare
// - with compare, flag sets only when true
// - sc1 write or low result read clears flag
// - flag with irq enable raises interrupt
// - single mode gives one conversion per start
// - continuous software mode runs after sc1 write
// - continuous hardware mode runs after trigger event
// - channel field selects inputs zero to thirty
// - all-ones channel powers off and isolates input
// - all-ones stop adds no extra conversion
// - single mode drops to low power after end
// - ten-bit compare uses high value two bits
// - eight-bit mode ignores high compare value
// - low compare byte meets low result byte
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_conversion_control
   import acc_pkg::*;
#(
   parameter int CONV_CYCLES = `ACC_CONV_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hwTrigPin,
   input wire logic [9:0] sampleData,
   output acc_front_t frontEnd,
   output logic convIrq
);
   // refuse counts the 8-bit counter cannot serve
   if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : gen_bad_cycles
      $error("CONV_CYCLES out of range");
   end

   localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

   // trigger synchroniser and edge detect
   logic trigS1_q, trigS2_q, trigS3_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigS1_q <= 1'b0;
         trigS2_q <= 1'b0;
         trigS3_q <= 1'b0;
      end else begin
         trigS1_q <= hwTrigPin;
         trigS2_q <= trigS1_q;
         trigS3_q <= trigS2_q;
      end
   end
   logic trigEdge;
   assign trigEdge = trigS2_q & ~trigS3_q;

   // bus decode
   logic acc, wrAcc, rdAcc, setup;
   assign acc = psel & penable;
   assign wrAcc = acc & pwrite;
   assign rdAcc = acc & ~pwrite;
   assign setup = psel & ~penable;
   assign pready = 1'b1;

   logic mapped;
   always_comb begin
      unique case (paddr)
         `ACC_OFF_SC1, `ACC_OFF_SC2, `ACC_OFF_RESH, `ACC_OFF_RESL,
         `ACC_OFF_CVH, `ACC_OFF_CVL, `ACC_OFF_IST, `ACC_OFF_IMSK:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end

   // register state
   logic flag_q, flag_d;
   logic irqEn_q, irqEn_d;
   logic cont_q, cont_d;
   logic [4:0] chan_q, chan_d;
   acc_cfg_t cfg_q, cfg_d;
   logic [7:0] cvh_q, cvh_d;
   logic [7:0] cvl_q, cvl_d;
   logic [9:0] res_q, res_d;
   logic [1:0] ist_q, ist_d;
   logic [1:0] imsk_q, imsk_d;
   acc_state_t state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic armed_q, armed_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;

   logic wrSc1, wrOff, rdResL, endConv, cmpTrue;
   logic [9:0] sampleRes, cmpRes, cmpVal;
   logic startReq;

   assign wrSc1 = wrAcc & (paddr == `ACC_OFF_SC1);
   assign wrOff = wrSc1 & (pwdata[4:0] == `ACC_CH_OFF);
   assign rdResL = rdAcc & (paddr == `ACC_OFF_RESL);
   assign endConv = (state_q == ACC_CONV) & (cnt_q == CONV_LAST);

   // result as it will be stored at the end
   assign sampleRes = cfg_q.mode10 ? sampleData : {2'b00, sampleData[9:2]};

   // compare value and operand
   always_comb begin
      if (cfg_q.mode10) begin
         cmpVal = {cvh_q[1:0], cvl_q};
         cmpRes = sampleRes;
      end else begin
         cmpVal = {2'b00, cvl_q};
         cmpRes = {2'b00, sampleRes[7:0]};
      end
   end
   assign cmpTrue = cfg_q.cmpGt ? (cmpRes >= cmpVal) : (cmpRes < cmpVal);

   // start request for the next cycle
   always_comb begin
      startReq = 1'b0;
      if (wrSc1 && !wrOff && !cfg_q.hwTrig) begin
         startReq = 1'b1;
      end
      if (trigEdge && cfg_q.hwTrig && armed_q && chan_q != `ACC_CH_OFF) begin
         startReq = 1'b1;
      end
   end

   // next-state logic
   always_comb begin
      flag_d = flag_q;
      irqEn_d = irqEn_q;
      cont_d = cont_q;
      chan_d = chan_q;
      cfg_d = cfg_q;
      cvh_d = cvh_q;
      cvl_d = cvl_q;
      res_d = res_q;
      ist_d = ist_q;
      imsk_d = imsk_q;
      state_d = state_q;
      cnt_d = cnt_q;
      armed_d = armed_q;
      rdata_d = rdata_q;
      err_d = err_q;

      // register writes
      if (wrAcc) begin
         unique case (paddr)
            `ACC_OFF_SC1: begin
               irqEn_d = pwdata[`ACC_SC1_IEN];
               cont_d = pwdata[`ACC_SC1_CONT];
               chan_d = pwdata[4:0];
               armed_d = pwdata[4:0] != `ACC_CH_OFF;
            end
            `ACC_OFF_SC2: begin
               cfg_d.hwTrig = pwdata[`ACC_SC2_HWT];
               cfg_d.cmpEn = pwdata[`ACC_SC2_CMPE];
               cfg_d.cmpGt = pwdata[`ACC_SC2_CMPGT];
               cfg_d.mode10 = pwdata[`ACC_SC2_M10];
            end
            `ACC_OFF_CVH: cvh_d = pwdata[7:0] & `ACC_CVH_MASK;
            `ACC_OFF_CVL: cvl_d = pwdata[7:0];
            `ACC_OFF_IST: ist_d = ist_q & ~pwdata[1:0];
            `ACC_OFF_IMSK: imsk_d = pwdata[1:0];
            default: ;
         endcase
      end

      // flag clear, then set wins
      if (wrSc1 || rdResL) begin
         flag_d = 1'b0;
      end

      // sequencer
      unique case (state_q)
         ACC_IDLE: begin
            cnt_d = 8'h00;
            if (startReq) begin
               state_d = ACC_CONV;
               if (!cont_d) begin
                  armed_d = 1'b0;
               end
            end
         end
         ACC_CONV: begin
            cnt_d = cnt_q + 8'h01;
            if (wrOff) begin
               state_d = ACC_IDLE;
               cnt_d = 8'h00;
            end else if (startReq) begin
               cnt_d = 8'h00;
               if (!cont_d) begin
                  armed_d = 1'b0;
               end
            end else if (endConv) begin
               cnt_d = 8'h00;
               res_d = sampleRes;
               ist_d[`ACC_IST_DONE] = 1'b1;
               if (!cfg_q.cmpEn) begin
                  flag_d = 1'b1;
               end else if (cmpTrue) begin
                  flag_d = 1'b1;
                  ist_d[`ACC_IST_MATCH] = 1'b1;
               end
               if (!cont_q || chan_q == `ACC_CH_OFF) begin
                  state_d = ACC_IDLE;
               end
            end
         end
      endcase

      // read data for the access phase
      if (setup) begin
         err_d = ~mapped;
         unique case (paddr)
            `ACC_OFF_SC1:
               rdata_d = {24'h0000_00, flag_q, irqEn_q, cont_q, chan_q};
            `ACC_OFF_SC2:
               rdata_d = {24'h0000_00, state_q == ACC_CONV, 3'b000,
                          cfg_q.mode10, cfg_q.cmpGt, cfg_q.cmpEn, cfg_q.hwTrig};
            `ACC_OFF_RESH:
               rdata_d = {30'h0000_0000, res_q[9:8]};
            `ACC_OFF_RESL:
               rdata_d = {24'h0000_00, res_q[7:0]};
            `ACC_OFF_CVH:
               rdata_d = {24'h0000_00, cvh_q};
            `ACC_OFF_CVL:
               rdata_d = {24'h0000_00, cvl_q};
            `ACC_OFF_IST:
               rdata_d = {30'h0000_0000, ist_q};
            `ACC_OFF_IMSK:
               rdata_d = {30'h0000_0000, imsk_q};
            default:
               rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // state registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
         irqEn_q <= 1'b0;
         cont_q <= 1'b0;
         chan_q <= `ACC_RST_CH;
         cfg_q <= '0;
         cvh_q <= `ACC_RST_BYTE;
         cvl_q <= `ACC_RST_BYTE;
         res_q <= 10'h000;
         ist_q <= 2'b00;
         imsk_q <= 2'b00;
         state_q <= ACC_IDLE;
         cnt_q <= 8'h00;
         armed_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irqEn_q <= irqEn_d;
         cont_q <= cont_d;
         chan_q <= chan_d;
         cfg_q <= cfg_d;
         cvh_q <= cvh_d;
         cvl_q <= cvl_d;
         res_q <= res_d;
         ist_q <= ist_d;
         imsk_q <= imsk_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         armed_q <= armed_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end

   assign prdata = rdata_q;
   assign pslverr = err_q & acc;

   // analog front end controls
   always_comb begin
      frontEnd.channel = chan_q;
      frontEnd.powerOn = (state_q == ACC_CONV) && (chan_q != `ACC_CH_OFF);
      frontEnd.isolate = (chan_q == `ACC_CH_OFF);
   end

   // interrupt output
   assign convIrq = (flag_q & irqEn_q) | (|(ist_q & imsk_q));

   // checks
   AST_FLAG_NOCMP: assert property (@(posedge sys_clk) disable iff (rst)
      endConv && !cfg_q.cmpEn && !wrOff && !startReq |=> flag_q)
      else $error("flag not set after conversion");

   AST_FLAG_CMPFALSE: assert property (@(posedge sys_clk) disable iff (rst)
      endConv && cfg_q.cmpEn && !cmpTrue && !flag_q |=> !flag_q)
      else $error("flag set on false compare");

   AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
      (wrSc1 || rdResL) && !endConv |=> !flag_q)
      else $error("flag not cleared");

   AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      flag_q && irqEn_q |-> convIrq)
      else $error("interrupt missing");

   AST_IST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      |(ist_q & imsk_q) |-> convIrq)
      else $error("masked status interrupt missing");

   AST_HW_UNARMED: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ACC_IDLE && cfg_q.hwTrig && !armed_q && !wrAcc |=> state_q == ACC_IDLE)
      else $error("unarmed trigger started a conversion");

   AST_SINGLE_END: assert property (@(posedge sys_clk) disable iff (rst)
      endConv && !cont_q && !startReq && !wrAcc |=> state_q == ACC_IDLE ##1
      state_q == ACC_IDLE || $past(startReq))
      else $error("single conversion did not stop");

   AST_CONT_RUN: assert property (@(posedge sys_clk) disable iff (rst)
      endConv && cont_q && chan_q != `ACC_CH_OFF && !wrAcc |=> state_q == ACC_CONV)
      else $error("continuous run stopped");

   AST_HW_START: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ACC_IDLE && trigEdge && cfg_q.hwTrig && armed_q &&
      chan_q != `ACC_CH_OFF && !wrAcc |=> state_q == ACC_CONV && cnt_q == 8'h00)
      else $error("hardware trigger did not start");

   AST_CHANNEL: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ACC_CONV |-> frontEnd.channel == chan_q)
      else $error("channel not presented");

   AST_OFF_ISOLATE: assert property (@(posedge sys_clk) disable iff (rst)
      chan_q == `ACC_CH_OFF |-> !frontEnd.powerOn && frontEnd.isolate)
      else $error("off code not honoured");

   AST_NO_EXTRA: assert property (@(posedge sys_clk) disable iff (rst)
      wrOff |=> state_q == ACC_IDLE [*2])
      else $error("extra conversion after stop");

   AST_LOW_POWER: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == ACC_IDLE |-> !frontEnd.powerOn)
      else $error("powered while idle");

   AST_CMP10: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_q.mode10 |-> cmpVal[9:8] == cvh_q[1:0])
      else $error("high compare bits unused");

   AST_CMP8: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_q.mode10 |-> cmpVal[9:8] == 2'b00 && cmpRes[9:8] == 2'b00)
      else $error("high compare used in 8-bit mode");

   AST_CMPLOW: assert property (@(posedge sys_clk) disable iff (rst)
      endConv |-> cmpVal[7:0] == cvl_q && cmpRes[7:0] == sampleRes[7:0])
      else $error("low compare byte wrong");

   AST_CVH_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
      cvh_q[7:2] == 6'h00)
      else $error("compare high upper bits set");

   COV_SINGLE: cover property (@(posedge sys_clk) disable iff (rst)
      endConv && !cont_q);
   COV_CONT: cover property (@(posedge sys_clk) disable iff (rst)
      endConv && cont_q ##1 state_q == ACC_CONV && cnt_q == 8'h00);
   COV_MATCH: cover property (@(posedge sys_clk) disable iff (rst)
      endConv && cfg_q.cmpEn && cmpTrue);
   COV_STOP: cover property (@(posedge sys_clk) disable iff (rst)
      wrOff && state_q == ACC_CONV);
endmodule : acc_conversion_control

// >>> bench/acc_conversion_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_conversion_control_bench
   import acc_pkg::*;
;
   localparam int NCYC = 4;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, hwTrigPin, convIrq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] sampleData;
   acc_front_t frontEnd;
   logic [64:0] expQ[$];
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 32'h3cbf_4542;
   logic [9:0] r, v;
   logic m10, gt, f;
   logic [7:0] cvh, cvl;

   acc_conversion_control #(.CONV_CYCLES(NCYC)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hwTrigPin(hwTrigPin), .sampleData(sampleData), .frontEnd(frontEnd), .convIrq(convIrq)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // read watcher: takes the oldest note at each completed read
   always @(posedge sys_clk) begin
      logic [64:0] e;
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : {1'b1, 64'h0000_0000_0000_0000};
         chk({31'h0000_0000, pslverr}, {31'h0000_0000, e[64]});
         chk(prdata & e[63:32], e[31:0] & e[63:32]);
      end
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic err = 1'b0);
      expQ.push_back({err, m, e});
      xfer(a, 1'b0, 32'h0000_0000);
   endtask : rd

   task automatic fe(input acc_front_t e);
      @(negedge sys_clk);
      chk({25'h000_0000, frontEnd}, {25'h000_0000, e});
   endtask : fe

   // waits for a conversion to start, then to end
   task automatic wait_done;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (frontEnd.powerOn !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      while (frontEnd.powerOn === 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_done

   task automatic pulse;
      @(posedge sys_clk);
      hwTrigPin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      hwTrigPin <= 1'b0;
   endtask : pulse

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      hwTrigPin = 1'b0;
      sampleData = 10'h000;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`ACC_OFF_SC1, 32'h0000_001F, '1);
      fe('{1'b0, 1'b1, 5'h1F});
      rd(`ACC_OFF_SC2, 32'h0000_0000, '1);
      rd(8'h20, 32'h0000_0000, '1, 1'b1);
      wr(`ACC_OFF_SC2, 32'h0000_0008);
      for (int ch = 0; ch < 8; ch++) begin
         sampleData <= 10'($random(seed));
         wr(`ACC_OFF_SC1, 32'h0000_0040 | ch);
         fe('{1'b1, 1'b0, 5'(ch)});
         wait_done();
         chk({31'h0000_0000, convIrq}, 32'h0000_0001);
         rd(`ACC_OFF_SC1, 32'h0000_00C0 | ch, '1);
         rd(`ACC_OFF_IST, 32'h0000_0001, 32'h0000_0001);
         repeat (2 * NCYC) fe('{1'b0, 1'b0, 5'(ch)});
         rd(`ACC_OFF_RESH, {30'h0000_0000, sampleData[9:8]}, '1);
         rd(`ACC_OFF_RESL, {24'h00_0000, sampleData[7:0]}, '1);
         rd(`ACC_OFF_SC1, 32'h0000_0040 | ch, '1);
         chk({31'h0000_0000, convIrq}, 32'h0000_0000);
      end
      wr(`ACC_OFF_IMSK, 32'h0000_0001);
      @(negedge sys_clk);
      chk({31'h0000_0000, convIrq}, 32'h0000_0001);
      wr(`ACC_OFF_IST, 32'h0000_0003);
      @(negedge sys_clk);
      chk({31'h0000_0000, convIrq}, 32'h0000_0000);
      for (int i = 0; i < 16; i++) begin
         {m10, gt} = 2'($random(seed));
         cvh = 8'($random(seed));
         cvl = 8'($random(seed));
         sampleData <= 10'($random(seed));
         wr(`ACC_OFF_CVH, {24'h00_0000, cvh});
         wr(`ACC_OFF_CVL, {24'h00_0000, cvl});
         wr(`ACC_OFF_SC2, {28'h000_0000, m10, gt, 2'b10});
         rd(`ACC_OFF_CVH, {30'h0000_0000, cvh[1:0]}, '1);
         wr(`ACC_OFF_SC1, 32'h0000_0002);
         wait_done();
         r = m10 ? sampleData : {2'b00, sampleData[9:2]};
         v = m10 ? {cvh[1:0], cvl} : {2'b00, cvl};
         f = gt ? (r >= v) : (r < v);
         rd(`ACC_OFF_SC1, {24'h00_0000, f, 7'h02}, '1);
         rd(`ACC_OFF_RESL, {24'h00_0000, r[7:0]}, '1);
         rd(`ACC_OFF_IST, {30'h0000_0000, f, 1'b1}, 32'h0000_0003);
         wr(`ACC_OFF_IST, 32'h0000_0003);
      end
      wr(`ACC_OFF_SC2, 32'h0000_0000);
      wr(`ACC_OFF_SC1, 32'h0000_0024);
      repeat (3 * NCYC + 2) fe('{1'b1, 1'b0, 5'h04});
      rd(`ACC_OFF_SC1, 32'h0000_00A4, '1);
      wr(`ACC_OFF_SC1, 32'h0000_003F);
      repeat (3 * NCYC) fe('{1'b0, 1'b1, 5'h1F});
      rd(`ACC_OFF_SC1, 32'h0000_003F, '1);
      wr(`ACC_OFF_SC2, 32'h0000_0001);
      wr(`ACC_OFF_SC1, 32'h0000_0006);
      repeat (NCYC + 4) fe('{1'b0, 1'b0, 5'h06});
      pulse();
      wait_done();
      rd(`ACC_OFF_SC1, 32'h0000_0086, '1);
      repeat (2 * NCYC) fe('{1'b0, 1'b0, 5'h06});
      wr(`ACC_OFF_SC1, 32'h0000_0027);
      pulse();
      repeat (3) @(negedge sys_clk);
      repeat (3 * NCYC + 2) fe('{1'b1, 1'b0, 5'h07});
      wr(`ACC_OFF_SC1, 32'h0000_003F);
      repeat (3 * NCYC) fe('{1'b0, 1'b1, 5'h1F});
      give_verdict();
   end
endmodule : acc_conversion_control_bench
